// [dws_pkg.sv]
// Package for the display word sequencer: register map, field layouts,
// word formats, counter states and timing counts.
// Assumes a 100 MHz system clock and a 32-bit Avalon-MM register bus.
package dws_pkg;

	// Register word indices (byte address is four times the index)
	localparam logic [1:0] IDX_CTRL = 2'h0;
	localparam logic [1:0] IDX_STATUS = 2'h1;
	localparam logic [1:0] IDX_DAC = 2'h2;
	localparam logic [1:0] IDX_DISPLAY = 2'h3;

	// Timing
	localparam int CLK_MHZ = 100;
	localparam int WORD_DELAY_US = 35;
	localparam int POINT_WAIT_US = 25;
	localparam int BEAM_ON_US = 10;
	localparam logic [11:0] WORD_CYC = 12'(WORD_DELAY_US * CLK_MHZ);
	localparam logic [11:0] POINT_WAIT_CYC = 12'(POINT_WAIT_US * CLK_MHZ);
	localparam logic [11:0] BEAM_ON_CYC = 12'(BEAM_ON_US * CLK_MHZ);

	// Word fields
	localparam int WORD_W = 16;
	localparam int COORD_W = 11;
	localparam int COORD_LSB = 5;
	localparam int START_BIT = 0;
	localparam logic START_VAL = 1'h1;
	localparam int W1_POLAR = 1;
	localparam int W1_LOG = 2;
	localparam int W1_FREQ = 3;
	localparam int W1_EIGHT_U = 4;
	localparam int W1_EIGHT_T = 7;
	localparam int W1_EIGHT_H = 10;
	localparam int W1_SIGN = 15;
	localparam int W2_UNITS = 1;
	localparam int W2_TENS = 4;
	localparam int W2_HUND = 7;
	localparam int W2_MULT = 13;
	localparam int W3_Z5 = 1;
	localparam int W4_Z1 = 1;

	// Register field positions
	localparam int ST_COUNT = 4;
	localparam int DAC_Y = 16;
	localparam int DISP_LAMP = 16;
	localparam int DISP_INT = 24;
	localparam logic [31:0] READ_ZERO = 32'h0000_0000;

	typedef enum logic [3:0] {
		CNT0 = 4'h1,
		CNT1 = 4'h2,
		CNT2 = 4'h4,
		CNT3 = 4'h8
	} dws_count_t;

	// Front-panel switch settings held in the control register
	typedef struct packed {
		logic marker_every_32;
		logic marker_every_8;
		logic complex_vmode_sel;
		logic plot_arm_qualifier;
		logic plot_function_sel;
		logic continuous_type_sel;
		logic point_type_sel;
	} dws_ctrl_t;

	typedef struct packed {
		logic mult5;
		logic mult2;
		logic mult1;
		logic rect;
		logic polar;
		logic log_db;
		logic freq;
		logic scale_sign_lamp;
	} dws_lamp_t;

endpackage

// [dws_sequencer.sv]
// Display word sequencer: host word port, word counter, DAC loads, beam
// unblanking, markers, plotter pacing and the Avalon-MM register slave.
// Assumes the host holds the word stable around its encode edge and that
// word, encode and plotter-done pins are asynchronous to SYS_CLK_IN.
//
// Contract
// - Word counter steps 0-1-2-3 then alternates 2-3
// - Start bit clears counter, else advance or 3-to-2
// - Host words are sixteen bits wide
// - Encode command yields one internal encode pulse
// - Route each word by active counter output
// - First word: polar, log, freq, eights, sign
// - Second word: units, tens, hundreds, multipliers
// - Lamps decoded from stored first two words
// - Encode clears ready; set again after 35 us
// - Count zero restarts marker; every 8 or 32
// - Count two drives horizontal load strobe
// - Count three drives vertical load strobe
// - Bar type returns vertical to mid-scale; done here only while complex mode and plot function are both off
// - Count three unblanks beam and external output
// - Point type: wait 25 us, beam on 10 us
// - Continuous type: X loads with following Y word
// - Plot at arm: hold ready after fourth word
// - Plot at plot: hold ready after first word
// - Plot request is the inverse of ready
// - Plotter done pulse sets ready after hold
// - Pen lift while plot qualifier and not count zero
// - Complex mode selects 8 cm sweep
//
// Chosen here: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps

module dws_sequencer (
	input wire logic SYS_CLK_IN,
	input wire logic RST_IN,
	input wire logic CE_IN,
	input wire logic [1:0] AVS_ADDRESS_IN,
	input wire logic AVS_READ_IN,
	input wire logic AVS_WRITE_IN,
	input wire logic [31:0] AVS_WRITEDATA_IN,
	output logic [31:0] AVS_READDATA_OUT,
	output logic AVS_WAITREQUEST_OUT,
	input wire logic [dws_pkg::WORD_W-1:0] HOST_WORD_IN,
	input wire logic HOST_ENCODE_IN,
	output logic WORD_READY_OUT,
	input wire logic PLOTTER_DONE_IN,
	output logic PLOT_REQ_OUT,
	output logic PEN_LIFT_OUT,
	output logic [3:0] COUNT_SEL_OUT,
	output logic [dws_pkg::COORD_W-1:0] X_DAC_OUT,
	output logic [dws_pkg::COORD_W-1:0] Y_DAC_OUT,
	output logic H_LOAD_OUT,
	output logic V_LOAD_OUT,
	output logic MID_SCALE_OUT,
	output logic BEAM_UNBLANK_OUT,
	output logic EXT_UNBLANK_OUT,
	output logic MARKER_OUT,
	output logic [4:0] INTENSITY_OUT,
	output logic SWEEP_8CM_OUT,
	output logic [11:0] DIGITS_OUT,
	output dws_pkg::dws_lamp_t LAMPS_OUT
);

	// Pin synchronisers; only stage two and later are read by logic
	logic [dws_pkg::WORD_W-1:0] word_s1_q, word_s2_q;
	logic enc_s1_q, enc_s2_q, enc_s3_q;
	logic done_s1_q, done_s2_q, done_s3_q;

	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			word_s1_q <= 16'h0000;
			word_s2_q <= 16'h0000;
			{enc_s1_q, enc_s2_q, enc_s3_q} <= 3'h0;
			{done_s1_q, done_s2_q, done_s3_q} <= 3'h0;
		end else if (CE_IN) begin
			word_s1_q <= HOST_WORD_IN;
			word_s2_q <= word_s1_q;
			{enc_s1_q, enc_s2_q, enc_s3_q} <= {HOST_ENCODE_IN, enc_s1_q, enc_s2_q};
			{done_s1_q, done_s2_q, done_s3_q} <= {PLOTTER_DONE_IN, done_s1_q, done_s2_q};
		end
	end

	// Control register and state
	dws_pkg::dws_ctrl_t ctrl_q;
	dws_pkg::dws_count_t state_q, state_d;
	logic ready_q, hold_q, busy_q;
	logic [11:0] dly_q;
	logic [dws_pkg::COORD_W-1:0] x_hold_q, x_dac_q, y_dac_q;
	logic h_load_q, v_load_q, mid_q, beam_q, mark_q;
	logic [4:0] pt_q, int_q;
	logic [8:0] w1_q;
	logic [11:0] w2_q;

	wire enc_rise = enc_s2_q & ~enc_s3_q;
	wire encode_pulse = CE_IN & enc_rise & ready_q;
	wire plot_done_pulse = CE_IN & done_s2_q & ~done_s3_q;
	wire is_start = word_s2_q[dws_pkg::START_BIT] == dws_pkg::START_VAL;
	wire [dws_pkg::COORD_W-1:0] coord_bits = word_s2_q[dws_pkg::COORD_LSB +: dws_pkg::COORD_W];
	wire count_zero_sel = state_q == dws_pkg::CNT0;
	wire count_one_sel = state_q == dws_pkg::CNT1;
	wire count_two_sel = state_q == dws_pkg::CNT2;
	wire count_three_sel = state_q == dws_pkg::CNT3;
	wire expire = CE_IN & busy_q & (dly_q == 12'h000);
	wire bar_mode = ~ctrl_q.point_type_sel & ~ctrl_q.continuous_type_sel;
	wire mid_mode = bar_mode & ~ctrl_q.complex_vmode_sel & ~ctrl_q.plot_function_sel;
	wire inhibit = ctrl_q.plot_function_sel &
		((~ctrl_q.plot_arm_qualifier & count_three_sel) |
		(ctrl_q.plot_arm_qualifier & count_zero_sel));
	wire point_window = (dly_q < dws_pkg::WORD_CYC - dws_pkg::POINT_WAIT_CYC) &&
		(dly_q >= dws_pkg::WORD_CYC - dws_pkg::POINT_WAIT_CYC - dws_pkg::BEAM_ON_CYC);
	wire beam_d = busy_q & count_three_sel & (~ctrl_q.point_type_sel | point_window);
	wire marker_hit = (ctrl_q.marker_every_8 & (pt_q[2:0] == 3'h0)) |
		(ctrl_q.marker_every_32 & (pt_q == 5'h00));

	// Word counter next state
	always_comb begin
		state_d = state_q;
		if (is_start) begin
			state_d = dws_pkg::CNT0;
		end else begin
			case (state_q)
				dws_pkg::CNT0: state_d = dws_pkg::CNT1;
				dws_pkg::CNT1: state_d = dws_pkg::CNT2;
				dws_pkg::CNT2: state_d = dws_pkg::CNT3;
				dws_pkg::CNT3: state_d = dws_pkg::CNT2;
				default: state_d = dws_pkg::CNT0;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			state_q <= dws_pkg::CNT0;
		end else if (encode_pulse) begin
			state_q <= state_d;
		end
	end

	// Ready flag, word delay and plotter hold
	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			ready_q <= 1'h1;
			hold_q <= 1'h0;
			busy_q <= 1'h0;
			dly_q <= 12'h000;
		end else if (CE_IN) begin
			if (encode_pulse) begin
				ready_q <= 1'h0;
				busy_q <= 1'h1;
				dly_q <= dws_pkg::WORD_CYC - 12'h001;
			end else if (expire) begin
				busy_q <= 1'h0;
				if (inhibit) begin
					hold_q <= 1'h1;
				end else begin
					ready_q <= 1'h1;
				end
			end else if (busy_q) begin
				dly_q <= dly_q - 12'h001;
			end else if (hold_q && plot_done_pulse) begin
				hold_q <= 1'h0;
				ready_q <= 1'h1;
			end
		end
	end

	// Word routing into display and DAC storage
	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			w1_q <= 9'h000;
			w2_q <= 12'h000;
			x_hold_q <= 11'h000;
			x_dac_q <= 11'h000;
			y_dac_q <= 11'h000;
			int_q <= 5'h00;
		end else if (encode_pulse) begin
			case (state_d)
				dws_pkg::CNT0: begin
					w1_q <= {word_s2_q[dws_pkg::W1_SIGN], word_s2_q[dws_pkg::W1_EIGHT_H],
						word_s2_q[dws_pkg::W1_EIGHT_T], word_s2_q[dws_pkg::W1_EIGHT_U],
						word_s2_q[dws_pkg::W1_FREQ], word_s2_q[dws_pkg::W1_LOG],
						word_s2_q[dws_pkg::W1_POLAR], 2'h0};
				end
				dws_pkg::CNT1: begin
					w2_q <= {word_s2_q[dws_pkg::W2_MULT +: 3], word_s2_q[dws_pkg::W2_UNITS +: 9]};
				end
				dws_pkg::CNT2: begin
					x_hold_q <= coord_bits;
					int_q[4] <= word_s2_q[dws_pkg::W3_Z5];
					if (!ctrl_q.continuous_type_sel) begin
						x_dac_q <= coord_bits;
					end
				end
				dws_pkg::CNT3: begin
					y_dac_q <= coord_bits;
					int_q[3:0] <= word_s2_q[dws_pkg::W4_Z1 +: 4];
					if (ctrl_q.continuous_type_sel) begin
						x_dac_q <= x_hold_q;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Load strobes, mid-scale, unblanking and markers
	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			h_load_q <= 1'h0;
			v_load_q <= 1'h0;
			mid_q <= 1'h0;
			beam_q <= 1'h0;
			mark_q <= 1'h0;
			pt_q <= 5'h00;
		end else if (CE_IN) begin
			h_load_q <= encode_pulse & ((state_d == dws_pkg::CNT2) & ~ctrl_q.continuous_type_sel |
				(state_d == dws_pkg::CNT3) & ctrl_q.continuous_type_sel);
			v_load_q <= encode_pulse & (state_d == dws_pkg::CNT3);
			mid_q <= expire & count_three_sel & mid_mode;
			beam_q <= beam_d;
			if (encode_pulse && state_d == dws_pkg::CNT0) begin
				pt_q <= 5'h00;
				mark_q <= 1'h0;
			end else if (encode_pulse && state_d == dws_pkg::CNT3) begin
				pt_q <= pt_q + 5'h01;
				mark_q <= marker_hit;
			end
		end
	end

	// Avalon-MM slave: one wait state, then the answer
	logic ack_q, bus_ack;
	logic [31:0] rdata_q;
	wire bus_req = AVS_READ_IN | AVS_WRITE_IN;
	wire bus_take = bus_req & ack_q;
	wire [31:0] status_word = {24'h00_0000, COUNT_SEL_OUT, 1'h0, beam_q, hold_q, ready_q};
	wire [31:0] dac_word = {5'h00, y_dac_q, 5'h00, x_dac_q};
	wire [31:0] disp_word = {3'h0, int_q, LAMPS_OUT, 4'h0, DIGITS_OUT};
	wire [31:0] read_mux =
		(AVS_ADDRESS_IN == dws_pkg::IDX_CTRL) ? {25'h000_0000, ctrl_q} :
		(AVS_ADDRESS_IN == dws_pkg::IDX_STATUS) ? status_word :
		(AVS_ADDRESS_IN == dws_pkg::IDX_DAC) ? dac_word :
		(AVS_ADDRESS_IN == dws_pkg::IDX_DISPLAY) ? disp_word : dws_pkg::READ_ZERO;
	assign bus_ack = bus_req & ~ack_q;

	always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			ack_q <= 1'h0;
			rdata_q <= 32'h0000_0000;
			ctrl_q <= '0;
		end else if (CE_IN) begin
			ack_q <= bus_ack;
			if (bus_ack) begin
				rdata_q <= AVS_READ_IN ? read_mux : dws_pkg::READ_ZERO;
			end
			if (bus_take && AVS_WRITE_IN && AVS_ADDRESS_IN == dws_pkg::IDX_CTRL) begin
				ctrl_q <= AVS_WRITEDATA_IN[6:0];
			end
		end
	end

	assign AVS_WAITREQUEST_OUT = bus_req & ~ack_q;
	assign AVS_READDATA_OUT = rdata_q;

	// Outputs
	assign WORD_READY_OUT = ready_q;
	assign PLOT_REQ_OUT = ~ready_q;
	assign PEN_LIFT_OUT = ctrl_q.plot_arm_qualifier & ~count_zero_sel;
	assign SWEEP_8CM_OUT = ctrl_q.complex_vmode_sel;
	assign COUNT_SEL_OUT = {count_three_sel, count_two_sel, count_one_sel, count_zero_sel};
	assign X_DAC_OUT = x_dac_q;
	assign Y_DAC_OUT = y_dac_q;
	assign H_LOAD_OUT = h_load_q;
	assign V_LOAD_OUT = v_load_q;
	assign MID_SCALE_OUT = mid_q;
	assign BEAM_UNBLANK_OUT = beam_q;
	assign EXT_UNBLANK_OUT = beam_q;
	assign MARKER_OUT = mark_q & beam_q;
	assign INTENSITY_OUT = int_q;
	// Digits: eights bit from the first word above the 1-2-4 bits of the second
	assign DIGITS_OUT = {w1_q[7], w2_q[8:6], w1_q[6], w2_q[5:3], w1_q[5], w2_q[2:0]};
	assign LAMPS_OUT.scale_sign_lamp = w1_q[8];
	assign LAMPS_OUT.freq = w1_q[4];
	assign LAMPS_OUT.log_db = w1_q[3];
	assign LAMPS_OUT.polar = w1_q[2];
	assign LAMPS_OUT.rect = ~w1_q[2];
	assign LAMPS_OUT.mult1 = w2_q[9];
	assign LAMPS_OUT.mult2 = w2_q[10];
	assign LAMPS_OUT.mult5 = w2_q[11];

	// Checks
	counter_alternate_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		encode_pulse && !is_start && count_three_sel |=> count_two_sel)
		else $error("counter did not step back from 3 to 2");

	start_clears_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		encode_pulse && is_start |=> count_zero_sel && !ready_q)
		else $error("start word did not clear the counter");

	ready_delay_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		encode_pulse |=> busy_q && dly_q == dws_pkg::WORD_CYC - 12'h001 && !ready_q)
		else $error("word delay not started on encode");

	ready_expiry_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		expire && !inhibit |=> ready_q && !busy_q)
		else $error("ready not set at end of word delay");

	encode_ignored_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		CE_IN && enc_rise && !ready_q |=> $stable(state_q) && $stable(y_dac_q) && $stable(x_dac_q))
		else $error("encode taken while ready was clear");

	horizontal_load_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		encode_pulse && state_d == dws_pkg::CNT2 && !ctrl_q.continuous_type_sel |=>
		h_load_q && x_dac_q == $past(coord_bits))
		else $error("horizontal load missed on count two");

	unblank_pair_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		encode_pulse && state_d == dws_pkg::CNT3 && !ctrl_q.point_type_sel |=> ##1 beam_q && EXT_UNBLANK_OUT)
		else $error("count three did not unblank the beam");

	vertical_load_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		encode_pulse && state_d == dws_pkg::CNT3 |=> v_load_q && y_dac_q == $past(coord_bits))
		else $error("vertical load missed on count three");

	point_beam_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		$rose(beam_q) && ctrl_q.point_type_sel && $stable(ctrl_q) |->
		dly_q == dws_pkg::WORD_CYC - dws_pkg::POINT_WAIT_CYC - 12'h002)
		else $error("point beam not after 25 us wait");

	plot_hold_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		expire && ctrl_q.plot_function_sel && !ctrl_q.plot_arm_qualifier && count_three_sel |=>
		hold_q && !ready_q)
		else $error("ready not withheld after fourth word at arm");

	plot_done_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		hold_q && !busy_q && !encode_pulse && plot_done_pulse |=> ready_q && !hold_q)
		else $error("plotter done did not set ready");

	mid_scale_a: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
		mid_q |-> $past(mid_mode) && $past(count_three_sel) && !busy_q)
		else $error("mid-scale outside bar point end");

endmodule

// [dws_host_model.sv]
// Host parallel card model: word lines, encode command and plotter done.
// Assumes the sequencer's ready flag is fed back on ready_in.
`timescale 1ns/1ps

module dws_host_model (
	input wire logic clk_in,
	input wire logic ready_in,
	output logic [15:0] word_out,
	output logic encode_out,
	output logic done_out
);
	initial begin
		word_out = 16'h0000;
		encode_out = 1'b0;
		done_out = 1'b0;
	end

	task automatic pulse_encode();
		@(posedge clk_in);
		encode_out <= 1'b1;
		repeat (4) @(posedge clk_in);
		encode_out <= 1'b0;
		repeat (2) @(posedge clk_in);
	endtask

	task automatic send_word(input logic [15:0] w);
		int n;
		n = 0;
		while (ready_in !== 1'b1 && n < 20000) begin
			@(negedge clk_in);
			n++;
		end
		@(posedge clk_in);
		word_out <= w;
		repeat (2) @(posedge clk_in);
		pulse_encode();
		// Released lines show the inverse, never the old word
		word_out <= ~w;
	endtask

	task automatic plot_done();
		@(posedge clk_in);
		done_out <= 1'b1;
		repeat (4) @(posedge clk_in);
		done_out <= 1'b0;
	endtask
endmodule

// [tb_display_word_sequencer.sv]
// Self-checking bench for the display word sequencer.
// Assumes dws_pkg, dws_sequencer and dws_host_model are compiled first.
`timescale 1ns/1ps

`define CHK(a, e, m) begin check_count++; if ((a) !== (e)) begin fail_count++; \
	$display("wrong value at %0t: %s", $time, m); end end

module tb_display_word_sequencer;
	logic clk, rst, ce, rd, wr, waitreq, enc, ready, pdone, preq, pen, hl, vl, mid, beam, ext, mark, sweep;
	logic [1:0] addr;
	logic [31:0] wdata, rdata, got;
	logic [15:0] word, w1, w2;
	logic [3:0] cnt;
	logic [10:0] xd, yd, xv, yv, x2;
	logic [4:0] inten;
	logic [11:0] digits;
	dws_pkg::dws_lamp_t lamps;
	int fail_count, check_count, low_n, beam_n, first_on, mark_n, ext_bad, hl_n, vl_n;
	logic mid_seen;

	dws_sequencer uut (.SYS_CLK_IN(clk), .RST_IN(rst), .CE_IN(ce), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd),
		.AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata), .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(waitreq),
		.HOST_WORD_IN(word), .HOST_ENCODE_IN(enc), .WORD_READY_OUT(ready), .PLOTTER_DONE_IN(pdone),
		.PLOT_REQ_OUT(preq), .PEN_LIFT_OUT(pen), .COUNT_SEL_OUT(cnt), .X_DAC_OUT(xd), .Y_DAC_OUT(yd),
		.H_LOAD_OUT(hl), .V_LOAD_OUT(vl), .MID_SCALE_OUT(mid), .BEAM_UNBLANK_OUT(beam), .EXT_UNBLANK_OUT(ext),
		.MARKER_OUT(mark), .INTENSITY_OUT(inten), .SWEEP_8CM_OUT(sweep), .DIGITS_OUT(digits), .LAMPS_OUT(lamps));

	dws_host_model host (.clk_in(clk), .ready_in(ready), .word_out(word), .encode_out(enc), .done_out(pdone));

	function automatic logic [15:0] xy_word(input logic [10:0] v, input logic [3:0] z);
		return {v, z, 1'b0};
	endfunction

	function automatic logic [11:0] exp_digits(input logic [15:0] a, input logic [15:0] b);
		return {a[10], b[9:7], a[7], b[6:4], a[4], b[3:1]};
	endfunction

	function automatic dws_pkg::dws_lamp_t exp_lamps(input logic [15:0] a, input logic [15:0] b);
		return dws_pkg::dws_lamp_t'({b[15], b[14], b[13], ~a[1], a[1], a[2], a[3], a[15]});
	endfunction

	task automatic bus_rw(input logic we, input logic [1:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= we;
		rd <= ~we;
		@(negedge clk);
		while (waitreq !== 1'b0) begin
			@(negedge clk);
		end
		@(posedge clk);
		got = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask

	// Sends one word and watches the outputs until ready returns or cap runs out
	task automatic run_word(input logic [15:0] w, input logic bad, input int cap);
		int n;
		n = 0;
		low_n = 0;
		beam_n = 0;
		first_on = -1;
		mark_n = 0;
		hl_n = 0;
		vl_n = 0;
		ext_bad = 0;
		mid_seen = 1'b0;
		fork
			begin
				host.send_word(w);
				if (bad) host.pulse_encode();
			end
		join_none
		while (ready !== 1'b0 && n < 40000) begin
			@(negedge clk);
			n++;
		end
		while (ready === 1'b0 && low_n < cap) begin
			if (beam === 1'b1 && first_on < 0) first_on = low_n;
			if (beam === 1'b1) beam_n++;
			if (mark === 1'b1) mark_n++;
			if (hl === 1'b1) hl_n++;
			if (vl === 1'b1) vl_n++;
			if (mid === 1'b1) mid_seen = 1'b1;
			if (ext !== beam) ext_bad++;
			low_n++;
			@(negedge clk);
		end
		if (mid === 1'b1) mid_seen = 1'b1;
	endtask

	task automatic report_and_stop();
		if (fail_count == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		repeat (80000) @(posedge clk);
		fail_count++;
		report_and_stop();
	end

	initial begin
		rst = 1'b1;
		ce = 1'b1;
		addr = 2'h0;
		rd = 1'b0;
		wr = 1'b0;
		wdata = 32'h0000_0000;
		fail_count = 0;
		check_count = 0;
		void'($urandom(32'hd7f6));
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		`CHK({cnt, ready, preq, beam, ext}, 8'h18, "state after reset")
		bus_rw(1'b0, dws_pkg::IDX_STATUS, 32'h0000_0000);
		`CHK(got[7:0], 8'h11, "status after reset")
		bus_rw(1'b1, dws_pkg::IDX_STATUS, 32'hFFFF_FFFF);
		bus_rw(1'b1, dws_pkg::IDX_CTRL, 32'h0000_0020);
		bus_rw(1'b0, dws_pkg::IDX_CTRL, 32'h0000_0000);
		`CHK(got[6:0], 7'h20, "control readback")
		w1 = 16'($urandom()) | 16'h0001;
		w2 = 16'($urandom()) & 16'hFFFE;
		run_word(w1, 1'b0, 8000);
		`CHK(cnt, 4'h1, "count after start word")
		`CHK(low_n, int'(dws_pkg::WORD_CYC), "ready low span")
		run_word(w2, 1'b0, 8000);
		`CHK(cnt, 4'h2, "count after second word")
		`CHK(digits, exp_digits(w1, w2), "digits")
		`CHK(lamps, exp_lamps(w1, w2), "lamps")
		// An encode shown while the clock enable is low must leave no trace
		@(posedge clk);
		ce <= 1'b0;
		host.send_word(xy_word(11'h7FF, 4'hF));
		repeat (8) @(posedge clk);
		ce <= 1'b1;
		repeat (8) @(negedge clk);
		`CHK({cnt, ready, xd}, {4'h2, 1'b1, 11'h000}, "frozen by clock enable")
		xv = 11'($urandom());
		yv = 11'($urandom());
		run_word(xy_word(xv, 4'h1), 1'b0, 8000);
		`CHK({cnt, xd, inten[4]}, {4'h4, xv, 1'b1}, "x word")
		`CHK({hl_n, vl_n}, {32'd1, 32'd0}, "x load strobe")
		run_word(xy_word(yv, 4'hA), 1'b0, 8000);
		`CHK({cnt, yd, inten[3:0]}, {4'h8, yv, 4'hA}, "y word")
		`CHK({hl_n, vl_n}, {32'd0, 32'd1}, "y load strobe")
		`CHK({beam_n > 3400, ext_bad, mid_seen}, {1'b1, 32'd0, 1'b1}, "bar point")
		`CHK(mark_n > 0, 1'b1, "marker on first point")
		bus_rw(1'b0, dws_pkg::IDX_DAC, 32'h0000_0000);
		`CHK({got[26:16], got[10:0]}, {yv, xv}, "dac readback")
		x2 = 11'($urandom());
		run_word(xy_word(x2, 4'h0), 1'b1, 8000);
		`CHK({cnt, xd, hl_n}, {4'h4, x2, 32'd1}, "encode while busy")
		bus_rw(1'b1, dws_pkg::IDX_CTRL, 32'h0000_0022);
		run_word(xy_word(yv, 4'h0), 1'b0, 8000);
		`CHK(mark_n, 0, "no marker on second point")
		run_word(xy_word(~x2, 4'h0), 1'b0, 8000);
		`CHK({xd, hl_n}, {x2, 32'd0}, "x held in continuous")
		run_word(xy_word(yv, 4'h0), 1'b0, 8000);
		`CHK({xd, mid_seen}, {~x2, 1'b0}, "x loaded with y")
		`CHK({hl_n, vl_n}, {32'd1, 32'd1}, "both strobes with y")
		bus_rw(1'b1, dws_pkg::IDX_CTRL, 32'h0000_0001);
		run_word(xy_word(xv, 4'h0), 1'b0, 8000);
		run_word(xy_word(yv, 4'h0), 1'b0, 8000);
		`CHK(first_on > 2495 && first_on < 2505, 1'b1, "point wait")
		`CHK(beam_n > 995 && beam_n < 1005, 1'b1, "point beam span")
		bus_rw(1'b1, dws_pkg::IDX_CTRL, 32'h0000_001C);
		@(negedge clk);
		`CHK(sweep, 1'b1, "sweep select")
		run_word(w1, 1'b0, 5000);
		`CHK({low_n, ready, preq, pen}, {32'd5000, 3'b010}, "hold after first word")
		host.plot_done();
		repeat (5) @(negedge clk);
		`CHK({ready, preq}, 2'b10, "done releases hold")
		run_word(w2, 1'b0, 8000);
		`CHK(pen, 1'b1, "pen lift")
		bus_rw(1'b1, dws_pkg::IDX_CTRL, 32'h0000_0004);
		run_word(xy_word(xv, 4'h0), 1'b0, 8000);
		run_word(xy_word(yv, 4'h0), 1'b0, 5000);
		`CHK({low_n, preq}, {32'd5000, 1'b1}, "hold after fourth word")
		host.plot_done();
		repeat (5) @(negedge clk);
		`CHK(ready, 1'b1, "done releases arm hold")
		report_and_stop();
	end
endmodule
